// ===== verif/cond_branch_overflow_saturation_test.sv
// self-checking bench for the overflow and saturation branches
`timescale 1ns/1ps
module cond_branch_overflow_saturation_test;
   import cond_branch_pkg::*;
   // ************************************************************
   // signals
   // ************************************************************
   typedef struct packed {
      logic [7:0]  opc;
      logic [15:0] st;
      logic [15:0] off;
      logic [23:0] pc;
      logic        taken;
   } row_t;
   // each code with its flag set, then cleared with every other bit set; last two rows: a backward taken branch and a pc wrap
   localparam row_t ROWS [10] = '{
      '{8'h0D, 16'h4000, 16'h0005, 24'h002000, 1'b1},
      '{8'h0D, 16'hBFFF, 16'h0005, 24'h002000, 1'b0},
      '{8'h30, 16'h0004, 16'h8000, 24'h020000, 1'b1},
      '{8'h30, 16'hFFFB, 16'h8000, 24'h020000, 1'b0},
      '{8'h0E, 16'h2000, 16'h7FFF, 24'h002000, 1'b1},
      '{8'h0E, 16'hDFFF, 16'h7FFF, 24'h002000, 1'b0},
      '{8'h0F, 16'h1000, 16'hFFFF, 24'h002000, 1'b1},
      '{8'h0F, 16'hEFFF, 16'hFFFF, 24'h002000, 1'b0},
      '{8'h0D, 16'h4000, 16'hFFFF, 24'h000000, 1'b1},
      '{8'h30, 16'h0000, 16'h0001, 24'hFFFFFE, 1'b0}};
   logic                clk         = 1'b0;
   logic                reset_n     = 1'b0;
   logic                instr_valid = 1'b0;
   logic [INSTR_W-1:0]  instr_word  = 24'h000000;
   logic [23:0]         instr_pc    = 24'h000000;
   logic [STATUS_W-1:0] status_word = 16'h0000;
   // index 0 earlier core, index 1 enhanced core
   logic [1:0]          rdy, ld, sq, tk, dn;
   logic [23:0]         pv [2];
   logic [23:0]         mpc [2];
   int unsigned         nsq [2];
   int                  n_taken  = 0;
   int                  n_errors = 0;
   int                  n_checks = 0;

   always #50 clk = ~clk;

   // ************************************************************
   // both core generations side by side on one issue port
   // ************************************************************
   for (genvar i = 0; i < 2; i++) begin : g_core
      cond_branch_overflow_saturation #(.PC_W(24), .ENHANCED(i == 1)) u_dut (
         .clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
         .instr_word(instr_word), .instr_pc(instr_pc), .instr_ready(rdy[i]),
         .status_word(status_word), .pc_load(ld[i]), .pc_value(pv[i]),
         .ir_squash(sq[i]), .branch_taken(tk[i]), .branch_done(dn[i]));
      pc_fetch_model u_pc (
         .clk(clk), .reset_n(reset_n), .pc_load(ld[i]), .pc_value(pv[i]),
         .ir_squash(sq[i]), .pc(mpc[i]), .n_squash(nsq[i]));
   end

   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic complete_run();
      $display("errors=%0d checks=%0d", n_errors, n_checks);
      if (n_errors == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run

   // one branch, then the done pulse timed on both cores
   task automatic issue(input row_t r);
      logic [23:0] e;
      e = r.pc + 24'h000002 + (r.taken ? {{7{r.off[15]}}, r.off, 1'b0} : 24'h000000);
      instr_word  = {r.opc, r.off};
      status_word = r.st;
      instr_pc    = r.pc;
      instr_valid = 1'b1;
      @(posedge clk);
      #1;
      instr_valid = 1'b0;
      status_word = ~r.st; // decision must already be latched
      n_taken += r.taken;
      for (int i = 0; i < 2; i++) begin
         chk(ld[i], 1'b1);
         chk(pv[i], e);
         chk(sq[i], r.taken);
         chk(tk[i], r.taken);
         chk(rdy[i], !r.taken);
      end
      for (int k = 1; k < 5; k++) begin
         chk(dn[0], k == (r.taken ? 2 : 1));
         chk(dn[1], k == (r.taken ? 4 : 1));
         @(posedge clk);
         #1;
      end
      chk(mpc[0], e);
      chk(mpc[1], e);
   endtask : issue

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      repeat (6) @(posedge clk);
      #1;
      chk({rdy, ld, sq, tk, dn}, 24'h000300);
      reset_n = 1'b1;
      @(posedge clk);
      #1;
      foreach (ROWS[j]) issue(ROWS[j]);
      // neighbouring code with every flag set is not ours
      instr_word  = {8'h0C, 16'h0001};
      instr_pc    = 24'h003000;
      status_word = 16'hFFFF;
      instr_valid = 1'b1;
      @(posedge clk);
      #1;
      chk(pv[0], 24'h000000);
      chk(pv[1], 24'h000000);
      chk({ld, tk, sq, dn}, 8'h00);
      chk(rdy, 2'b11);
      // back to back, flag read live in each accept cycle
      instr_word  = {8'h0F, 16'h0003};
      instr_pc    = 24'h000100;
      status_word = 16'h0000;
      instr_valid = 1'b1;
      @(posedge clk);
      #1;
      instr_pc    = 24'h000102;
      status_word = 16'h1000;
      chk(pv[1], 24'h000102);
      chk(dn, 2'b11);
      @(posedge clk);
      #1;
      n_taken++;
      chk(pv[1], 24'h00010A);
      chk(tk, 2'b11);
      // a word offered while busy is refused
      instr_pc = 24'h000400;
      instr_valid = 1'b1;
      @(posedge clk);
      #1;
      instr_valid = 1'b0;
      chk(ld, 2'b00);
      chk(pv[0], 24'h00010A);
      repeat (4) @(posedge clk);
      #1;
      chk(nsq[0], n_taken);
      chk(nsq[1], n_taken);
      // reset in the middle of a taken branch clears every output except instr_ready, which returns high
      instr_word  = {8'h0E, 16'h0010};
      instr_pc    = 24'h000200;
      status_word = 16'h2000;
      instr_valid = 1'b1;
      @(posedge clk);
      #1;
      instr_valid = 1'b0;
      reset_n     = 1'b0;
      @(posedge clk);
      #1;
      chk({rdy, ld, sq, tk, dn}, 24'h000300);
      reset_n = 1'b1;
      @(posedge clk);
      #1;
      chk({rdy, ld, sq, tk, dn}, 24'h000300);
      chk(mpc[1], 24'h000000);
      issue(ROWS[0]);
      complete_run();
   end

   // watchdog well beyond the expected seventy or so cycles
   initial begin
      #(2000 * 100);
      n_errors++;
      complete_run();
   end
endmodule : cond_branch_overflow_saturation_test

// ===== verif/pc_fetch_model.sv
// behavioural program counter and fetch slot beside the branch logic
`timescale 1ns/1ps
module pc_fetch_model (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // from the branch logic
   input  wire logic        pc_load,
   input  wire logic [23:0] pc_value,
   input  wire logic        ir_squash,
   // program counter state
   output logic [23:0]      pc,
   output int unsigned      n_squash
);
   // ************************************************************
   // program counter
   // ************************************************************
   // pc only moves on a load pulse, so a stray pulse shows up later
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc <= 24'h000000;
      end else if (pc_load) begin
         pc <= pc_value;
      end
   end

   // squashed fetch slots, each one becomes a no-op
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         n_squash <= 0;
      end else if (ir_squash) begin
         n_squash <= n_squash + 1;
      end
   end
endmodule : pc_fetch_model

// ===== verilog/branch_hold_timer.sv
// down-counter that times the extra cycles of a taken branch
`timescale 1ns/1ps
module branch_hold_timer #(
   parameter int CNT_W = 3
)(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset_n,
   // control
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] load_value,
   // status
   output logic                  final_tick
);

   logic [CNT_W-1:0] count;

   if (CNT_W < 1) begin : g_chk
      $error("branch_hold_timer: CNT_W must be at least 1");
   end

   // load wins over the running count
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count <= '0;
      end else if (load) begin
         count <= load_value;
      end else if (count != '0) begin
         count <= count - CNT_W'(1);
      end
   end

   // last hold cycle: count about to reach zero
   assign final_tick = (count == CNT_W'(1));

endmodule : branch_hold_timer

// ===== verilog/cond_branch_overflow_saturation.sv
// decode and execute of the overflow and saturation conditional branches
`timescale 1ns/1ps
module cond_branch_overflow_saturation
   import cond_branch_pkg::*;
#(
   parameter int PC_W     = 24,
   parameter bit ENHANCED = 1'b0
)(
   // clock and reset
   input  wire logic                clk,
   input  wire logic                reset_n,
   // instruction issue
   input  wire logic                instr_valid,
   input  wire logic [INSTR_W-1:0]  instr_word,
   input  wire logic [PC_W-1:0]     instr_pc,
   output logic                     instr_ready,
   // status register view
   input  wire logic [STATUS_W-1:0] status_word,
   // program counter and squash
   output logic                     pc_load,
   output logic [PC_W-1:0]          pc_value,
   output logic                     ir_squash,
   output logic                     branch_taken,
   output logic                     branch_done
);

   // ************************************************************
   // elaboration checks and derived counts
   // ************************************************************
   localparam int TAKEN_CYC = ENHANCED ? CYC_TAKEN_ENH : CYC_TAKEN_EARLY;
   localparam int HOLD_CYC  = TAKEN_CYC - CYC_NOT_TAKEN;

   // the doubled offset plus sign needs 18 bits of pc
   if (PC_W < OFF_W + 2) begin : g_chk_pc
      $error("cond_branch: PC_W too narrow for the offset");
   end
   if (HOLD_CYC < 1 || HOLD_CYC >= (1 << HOLD_W)) begin : g_chk_hold
      $error("cond_branch: hold count does not fit the timer");
   end
   // the doubling is a wired shift, so only a scale of two is served
   if (OFFSET_SCALE != 2) begin : g_chk_scale
      $error("cond_branch: offset scale must be two");
   end
   // an untaken branch answers at the very next edge, nothing slower
   if (CYC_NOT_TAKEN != 1) begin : g_chk_untaken
      $error("cond_branch: untaken branch must take one cycle");
   end

   typedef enum logic [0:0] {
      st_idle,
      st_hold
   } st_t;

   // ************************************************************
   // program counter arithmetic
   // ************************************************************

   // address of the next sequential word
   function automatic logic [PC_W-1:0] pc_step(input logic [PC_W-1:0] pc);
      return pc + PC_W'(PC_STEP);
   endfunction : pc_step

   // sign-extended offset counted in instructions, doubled to bytes
   function automatic logic [PC_W-1:0] pc_offset(input logic [PC_W-1:0] base,
                                                 input logic [OFF_W-1:0] off);
      logic [PC_W-1:0] ext;
      ext = {{(PC_W-OFF_W-1){off[OFF_W-1]}}, off, 1'b0};
      return base + ext;
   endfunction : pc_offset

   // ************************************************************
   // decode
   // ************************************************************
   cond_sel_t       sel;
   logic            hit;
   logic            cond;
   logic            accept;
   logic [PC_W-1:0] next_seq;
   logic [PC_W-1:0] next_taken;
   st_t             state;
   logic            final_tick;

   // whole branch sits in one word: code on top, offset below
   always_comb begin
      sel        = decode_cond(instr_word[OPC_MSB:OPC_LSB]);
      hit        = (sel != sel_none);
      cond       = flag_for(sel, status_word);
      accept     = instr_valid && instr_ready && hit;
      next_seq   = pc_step(instr_pc);
      next_taken = pc_offset(next_seq, instr_word[OFF_MSB:0]);
   end

   // ************************************************************
   // taken-branch hold timing
   // ************************************************************

   // timer keeps the issue port closed for the extra cycles
   branch_hold_timer #(
      .CNT_W      (HOLD_W)
   ) u_hold (
      .clk        (clk),
      .reset_n    (reset_n),
      .load       (accept && cond),
      .load_value (HOLD_W'(HOLD_CYC)),
      .final_tick (final_tick)
   );

   // idle until a taken branch, then hold until the timer ends
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= st_idle;
      end else begin
         case (state)
            st_idle: begin
               if (accept && cond) begin
                  state <= st_hold;
               end
            end
            st_hold: begin
               if (final_tick) begin
                  state <= st_idle;
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   // issue port closed while a taken branch still runs
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         instr_ready <= 1'b1;
      end else if (accept && cond) begin
         instr_ready <= 1'b0;
      end else if (state == st_hold && final_tick) begin
         instr_ready <= 1'b1;
      end
   end

   // ************************************************************
   // program counter and instruction register effects
   // ************************************************************

   // one load per branch: target if taken, else next word
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pc_load  <= 1'b0;
         pc_value <= '0;
      end else begin
         pc_load <= accept;
         if (accept) begin
            pc_value <= cond ? next_taken : next_seq;
         end
      end
   end

   // the slot already fetched behind a taken branch becomes a no-op
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ir_squash <= 1'b0;
      end else begin
         ir_squash <= accept && cond;
      end
   end

   // decision held as a level until the next branch is taken in
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         branch_taken <= 1'b0;
      end else if (accept) begin
         branch_taken <= cond;
      end
   end

   // completion pulse; status is only read here, never written back
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         branch_done <= 1'b0;
      end else begin
         branch_done <= (accept && !cond) || (state == st_hold && final_tick);
      end
   end

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   logic [31:0]     off_ext;
   logic [PC_W-1:0] exp_target;
   logic [3:0]      busy_len;
   logic [7:0]      opc;
   logic            own_code;

   // independent model of the target for checking only
   always_comb begin
      opc        = instr_word[OPC_MSB:OPC_LSB];
      off_ext    = 32'($signed(instr_word[OFF_MSB:0]));
      exp_target = instr_pc + PC_W'(PC_STEP) + PC_W'(off_ext * OFFSET_SCALE);
      own_code   = (opc == OPC_ACC_B_WRAP) || (opc == OPC_ARITH_WRAP)
                   || (opc == OPC_ACC_A_CLAMPED) || (opc == OPC_ACC_B_CLAMPED);
   end

   // cycles an accepted branch has occupied so far
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         busy_len <= '0;
      end else if (accept) begin
         busy_len <= 4'h1;
      end else if (!instr_ready) begin
         busy_len <= busy_len + 4'h1;
      end
   end

   a_acc_b_wrap: assert property (
      (accept && opc == OPC_ACC_B_WRAP) |=>
         branch_taken == $past(status_word[ACC_B_WRAP_BIT]))
      else $error("acc B wrap branch decided wrongly");

   a_arith_wrap: assert property (
      (accept && opc == OPC_ARITH_WRAP) |=>
         branch_taken == $past(status_word[ARITH_WRAP_BIT]))
      else $error("arith wrap branch decided wrongly");

   a_acc_a_clamp: assert property (
      (accept && opc == OPC_ACC_A_CLAMPED) |=>
         branch_taken == $past(status_word[ACC_A_CLAMP_BIT]))
      else $error("acc A clamp branch decided wrongly");

   a_acc_b_clamp: assert property (
      (accept && opc == OPC_ACC_B_CLAMPED) |=>
         branch_taken == $past(status_word[ACC_B_CLAMP_BIT]))
      else $error("acc B clamp branch decided wrongly");

   a_taken_target: assert property (
      (accept && cond) |=> pc_load && pc_value == $past(exp_target))
      else $error("taken branch target wrong");

   a_squash_taken: assert property (
      accept |=> ir_squash == branch_taken && pc_load)
      else $error("squash does not match branch decision");

   a_branch_length: assert property (
      branch_done |-> busy_len ==
         (branch_taken ? 4'(TAKEN_CYC) : 4'(CYC_NOT_TAKEN)))
      else $error("branch took the wrong number of cycles");

   a_one_word_step: assert property (
      (accept && !cond) |=> pc_load && branch_done && !ir_squash
         && pc_value == $past(instr_pc) + PC_W'(PC_STEP))
      else $error("untaken branch did not step one word");

   a_port_closed: assert property (
      (accept && cond) |=> !instr_ready ##1 !pc_load)
      else $error("issue port open during taken branch");

   // codes outside the four must not load the pc or squash, and must leave branch_taken alone
   a_foreign_code: assert property (
      (instr_valid && instr_ready && !own_code) |=>
         !pc_load && !ir_squash && $stable(branch_taken))
      else $error("foreign code changed the branch outputs");

   a_refused_busy: assert property (
      !instr_ready |=> !pc_load && !ir_squash)
      else $error("word taken in while the port was closed");

   a_squash_pulse: assert property (
      ir_squash |=> !ir_squash)
      else $error("squash lasted more than one slot");

   a_value_holds: assert property (
      !(instr_valid && instr_ready && own_code) |=> $stable(pc_value) && $stable(branch_taken))
      else $error("branch outputs moved without a branch");

   a_ready_on_done: assert property (
      branch_done |-> instr_ready)
      else $error("branch finished with the port still closed");

   a_untaken_open: assert property (
      (accept && !cond) |=> instr_ready)
      else $error("untaken branch closed the issue port");

   // main scenarios the bench should reach
   c_taken: cover property (accept && cond ##1 ir_squash);
   c_refused: cover property (instr_valid && !instr_ready);
   c_not_taken: cover property (accept && !cond ##1 branch_done);
   c_back_to_back: cover property (branch_done && branch_taken ##0 accept);
   c_backward: cover property (accept && cond && instr_word[OFF_MSB]);

endmodule : cond_branch_overflow_saturation

// ===== verilog/cond_branch_pkg.sv
// constants and types for the overflow and saturation conditional branches
package cond_branch_pkg;

   // ************************************************************
   // instruction word layout
   // ************************************************************
   localparam int INSTR_W = 24;
   localparam int OPC_MSB = 23;
   localparam int OPC_LSB = 16;
   localparam int OFF_MSB = 15;
   localparam int OFF_W   = 16;

   // upper-byte codes of the four branches
   localparam logic [7:0] OPC_ACC_B_WRAP    = 8'h0D;
   localparam logic [7:0] OPC_ARITH_WRAP    = 8'h30;
   localparam logic [7:0] OPC_ACC_A_CLAMPED = 8'h0E;
   localparam logic [7:0] OPC_ACC_B_CLAMPED = 8'h0F;

   // ************************************************************
   // status word layout
   // ************************************************************
   localparam int STATUS_W         = 16;
   localparam int ACC_B_WRAP_BIT   = 14;
   localparam int ACC_A_CLAMP_BIT  = 13;
   localparam int ACC_B_CLAMP_BIT  = 12;
   localparam int ARITH_WRAP_BIT   = 2;

   // ************************************************************
   // program counter arithmetic and cycle counts
   // ************************************************************
   localparam int PC_STEP         = 2;
   localparam int OFFSET_SCALE    = 2;
   localparam int CYC_NOT_TAKEN   = 1;
   localparam int CYC_TAKEN_EARLY = 2;
   localparam int CYC_TAKEN_ENH   = 4;
   localparam int HOLD_W          = 3;

   // which flag a decoded branch tests
   typedef enum logic [2:0] {
      sel_none,
      sel_acc_b_wrap,
      sel_arith_wrap,
      sel_acc_a_clamped,
      sel_acc_b_clamped
   } cond_sel_t;

   // upper byte to condition select
   function automatic cond_sel_t decode_cond(input logic [7:0] opc);
      cond_sel_t sel;
      sel = sel_none;
      if (opc == OPC_ACC_B_WRAP) begin
         sel = sel_acc_b_wrap;
      end else if (opc == OPC_ARITH_WRAP) begin
         sel = sel_arith_wrap;
      end else if (opc == OPC_ACC_A_CLAMPED) begin
         sel = sel_acc_a_clamped;
      end else if (opc == OPC_ACC_B_CLAMPED) begin
         sel = sel_acc_b_clamped;
      end
      return sel;
   endfunction : decode_cond

   // flag picked out of the live status word
   function automatic logic flag_for(input cond_sel_t sel,
                                     input logic [STATUS_W-1:0] status_word);
      logic f;
      f = 1'b0;
      case (sel)
         sel_acc_b_wrap:    f = status_word[ACC_B_WRAP_BIT];
         sel_arith_wrap:    f = status_word[ARITH_WRAP_BIT];
         sel_acc_a_clamped: f = status_word[ACC_A_CLAMP_BIT];
         sel_acc_b_clamped: f = status_word[ACC_B_CLAMP_BIT];
         default:           f = 1'b0;
      endcase
      return f;
   endfunction : flag_for

endpackage : cond_branch_pkg
